// File: hw/dpsr_top.sv
// DPLL status and rate pin block: mode control, indicators, rate word,
// secondary reference monitor and a classic Wishbone register slave.
// Assumes every input is synchronous to clk_i and the loop lives outside.
`timescale 1ns/10ps
`default_nettype none
module dpsr_top #(
    parameter int unsigned WINDOW_CYCLES = dpsr_pkg::WINDOW_CYCLES
) (
    input  wire logic        clk_i,                  // Master clock.
    input  wire logic        rst_i,                  // Synchronous reset.
    input  wire logic        pin_control_select_i,   // High: pin mode.
    input  wire logic        ds3_select_pin_i,       // Pin: DS3 rate.
    input  wire logic        high_rate_output_select_i, // Pin: full rate.
    input  wire logic        fast_acquire_req_i,     // Pin: fast lock.
    input  wire logic        ref_select_sec_pin_i,   // Pin: secondary ref.
    input  wire logic [1:0]  ref_freq_select_pin_i,  // Pin: ref frequency.
    input  wire logic        phase_continuity_ctrl_i, // Continuity control.
    input  wire logic        frame_pulse_8k_i,       // 8 kHz frame pulse.
    input  wire logic        ref_fail_i,             // Selected ref impaired.
    input  wire logic        loop_freq_locked_i,     // Loop in frequency lock.
    input  wire logic        sec_ref_tick_i,         // One per sec ref cycle.
    input  wire logic        wb_cyc_i,               // Wishbone cycle.
    input  wire logic        wb_stb_i,               // Wishbone strobe.
    input  wire logic        wb_we_i,                // Wishbone write.
    input  wire logic [3:0]  wb_adr_i,               // Byte address.
    input  wire logic [3:0]  wb_sel_i,               // Byte enables.
    input  wire logic [31:0] wb_dat_i,               // Write data.
    output logic      [31:0] wb_dat_o,               // Read data.
    output logic             wb_ack_o,               // Acknowledge.
    output logic             holdover_o,             // Holdover indicator.
    output logic             lock_o,                 // Lock indicator.
    output logic             secondary_ref_out_of_range_o, // Sec ref OOR.
    output logic             fast_lock_o,            // Fast loop gain.
    output logic             phase_realign_o,        // Realign pulse.
    output logic [31:0]      e3_ds3_clock_word_o,    // Synthesiser word.
    output logic             irq_o                   // Level interrupt.
);

    // Control, mask and sticky interrupt state.
    logic [5:0]                ctrl_r;               // Microport controls.
    logic [3:0]                irq_stat_r;           // Sticky events.
    logic [3:0]                irq_mask_r;           // Interrupt enables.
    logic                      ack_r;                // Bus acknowledge.
    logic [31:0]               rdata_r;              // Registered read data.
    dpsr_pkg::dpsr_mode_t      mode_r;               // Operating mode.
    dpsr_pkg::dpsr_mode_t      mode_nxt;             // Next mode.
    logic                      frame_prev_r;         // Frame pulse delay.
    logic                      pcc_r;                // Sampled continuity.
    logic                      lock_prev_r;          // Lock one cycle ago.
    logic [31:0]               win_cnt_r;            // Window position.
    logic [31:0]               tick_cnt_r;           // Ticks this window.
    logic                      oor_prev_r;           // Flag one cycle ago.
    logic                      hold_prev_r;          // Holdover one cycle ago.

    // Effective controls: pins in pin mode, register bits otherwise.
    logic                      eff_ds3;
    logic                      eff_full;
    logic                      eff_fast;
    logic                      eff_sec;
    logic [1:0]                eff_freq;
    logic                      frame_rise;
    logic                      win_end;
    logic                      bus_req;
    logic                      wr_en;
    logic [3:0]                irq_set;
    logic [3:0]                irq_clr;
    logic [31:0]               nominal;
    logic [31:0]               limit;
    logic [31:0]               deviation;
    logic [31:0]               cnt_fin;              // Ticks incl. last cycle.
    logic                      pcc_now;              // Continuity in force.

    // The board ties the select pin, so it is used without filtering.
    assign eff_ds3  = pin_control_select_i ? ds3_select_pin_i
                                           : ctrl_r[dpsr_pkg::CTRL_DS3];
    assign eff_full = pin_control_select_i ? high_rate_output_select_i
                                           : ctrl_r[dpsr_pkg::CTRL_FULL];
    // The fast request pin has no path at all in microport mode.
    assign eff_fast = pin_control_select_i ? fast_acquire_req_i
                                           : ctrl_r[dpsr_pkg::CTRL_FAST];
    assign eff_sec  = pin_control_select_i ? ref_select_sec_pin_i
                                           : ctrl_r[dpsr_pkg::CTRL_SEC];
    assign eff_freq = pin_control_select_i ? ref_freq_select_pin_i
                    : ctrl_r[dpsr_pkg::CTRL_FREQ_LO +: 2];

    // A bus access counts only while both cycle and strobe are high.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_en   = bus_req && wb_we_i;

    // Rising edge of the frame pulse.
    assign frame_rise = frame_pulse_8k_i && !frame_prev_r;

    // Frame pulse delay for edge detection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_prev_r <= 1'b0;
        end else begin
            frame_prev_r <= frame_pulse_8k_i;
        end
    end

    // Continuity control is caught only at the frame pulse rise, so the
    // board must hold it steady around that edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcc_r <= 1'b0;
        end else if (frame_rise) begin
            pcc_r <= phase_continuity_ctrl_i;
        end
    end

    // Mode transitions; primary holdover exits wait for a frame pulse rise so that
    // the continuity level used is the one just sampled.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            dpsr_pkg::FREERUN: begin
                if (!ref_fail_i) begin
                    mode_nxt = eff_sec ? dpsr_pkg::SEC_NORMAL
                                       : dpsr_pkg::PRI_NORMAL;
                end
            end
            dpsr_pkg::PRI_NORMAL: begin
                if (ref_fail_i) begin
                    mode_nxt = dpsr_pkg::PRI_HOLD;
                end else if (eff_sec) begin
                    mode_nxt = dpsr_pkg::SEC_NORMAL;
                end
            end
            dpsr_pkg::SEC_NORMAL: begin
                if (ref_fail_i) begin
                    mode_nxt = dpsr_pkg::SEC_HOLD;
                end else if (!eff_sec) begin
                    mode_nxt = dpsr_pkg::PRI_NORMAL;
                end
            end
            dpsr_pkg::PRI_HOLD: begin
                if (!ref_fail_i && frame_rise) begin
                    mode_nxt = eff_sec ? dpsr_pkg::SEC_NORMAL
                                       : dpsr_pkg::PRI_NORMAL;
                end
            end
            dpsr_pkg::SEC_HOLD: begin
                if (!ref_fail_i) begin
                    mode_nxt = dpsr_pkg::SEC_NORMAL;
                end
            end
            default: begin
                mode_nxt = dpsr_pkg::FREERUN;
            end
        endcase
    end

    // Mode register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= dpsr_pkg::FREERUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // The exit edge is itself a frame rise, so the level being sampled at
    // that edge decides; the held copy would be one frame stale.
    assign pcc_now = frame_rise ? phase_continuity_ctrl_i : pcc_r;

    // Leaving primary holdover with continuity low realigns the output
    // phase; with it high the phase is carried over unchanged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_realign_o <= 1'b0;
        end else begin
            phase_realign_o <= (mode_r == dpsr_pkg::PRI_HOLD)
                            && (mode_nxt != dpsr_pkg::PRI_HOLD) && !pcc_now;
        end
    end

    // Indicators are plain flip-flops so the pins never glitch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            holdover_o  <= 1'b0;
            lock_o      <= 1'b0;
            fast_lock_o <= 1'b0;
            lock_prev_r <= 1'b0;
        end else begin
            // High in either holdover mode, low otherwise.
            holdover_o  <= (mode_nxt == dpsr_pkg::PRI_HOLD)
                        || (mode_nxt == dpsr_pkg::SEC_HOLD);
            // Lock means frequency lock to a reference in normal mode.
            lock_o      <= loop_freq_locked_i
                        && ((mode_nxt == dpsr_pkg::PRI_NORMAL)
                        ||  (mode_nxt == dpsr_pkg::SEC_NORMAL));
            // Fast gain trades wander for a shorter acquisition.
            fast_lock_o <= eff_fast;
            lock_prev_r <= lock_o;
        end
    end

    // Synthesiser word for the high-rate clock; the quarter option
    // divides the word, which a real output divider would mirror.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            e3_ds3_clock_word_o <= 32'h0;
        end else if (eff_full) begin
            e3_ds3_clock_word_o <= eff_ds3 ? dpsr_pkg::SYN_DS3_WORD
                                           : dpsr_pkg::SYN_E3_WORD;
        end else begin
            // Select low: one quarter of the nominal rate.
            e3_ds3_clock_word_o <= (eff_ds3 ? dpsr_pkg::SYN_DS3_WORD
                                            : dpsr_pkg::SYN_E3_WORD)
                                 / dpsr_pkg::QUARTER_DIV;
        end
    end

    // Expected ticks per window and the 12 ppm allowance; the nominal
    // scales with the window so a short window still reads correctly.
    always_comb begin
        case (eff_freq)
            2'h0:    nominal = 32'((64'(dpsr_pkg::REF_HZ_0) * WINDOW_CYCLES)
                                   / dpsr_pkg::CLK_HZ);
            2'h1:    nominal = 32'((64'(dpsr_pkg::REF_HZ_1) * WINDOW_CYCLES)
                                   / dpsr_pkg::CLK_HZ);
            2'h2:    nominal = 32'((64'(dpsr_pkg::REF_HZ_2) * WINDOW_CYCLES)
                                   / dpsr_pkg::CLK_HZ);
            default: nominal = 32'((64'(dpsr_pkg::REF_HZ_3) * WINDOW_CYCLES)
                                   / dpsr_pkg::CLK_HZ);
        endcase
        limit     = 32'((64'(nominal) * dpsr_pkg::OOR_PPM) / 1000000);
        // A tick on the closing cycle still belongs to this window.
        cnt_fin   = tick_cnt_r + 32'(sec_ref_tick_i);
        deviation = (cnt_fin > nominal) ? cnt_fin - nominal
                                        : nominal - cnt_fin;
    end

    // Window counter runs from the master clock alone.
    assign win_end = (win_cnt_r == 32'(WINDOW_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || win_end) begin
            win_cnt_r <= 32'h0;
        end else begin
            win_cnt_r <= win_cnt_r + 32'h1;
        end
    end

    // Tick count restarts every window; a tick on the last cycle is kept
    // in the closing window.
    always_ff @(posedge clk_i) begin
        if (rst_i || win_end) begin
            tick_cnt_r <= 32'h0;
        end else if (sec_ref_tick_i) begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // The flag changes only at a window end.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            secondary_ref_out_of_range_o <= 1'b0;
            oor_prev_r                   <= 1'b0;
        end else begin
            oor_prev_r <= secondary_ref_out_of_range_o;
            if (win_end) begin
                secondary_ref_out_of_range_o <= (deviation > limit);
            end
        end
    end

    // Events; a set in the same cycle as a clear wins.
    assign irq_set[dpsr_pkg::IRQ_HOLD]     = holdover_o && !hold_prev_r;
    assign irq_set[dpsr_pkg::IRQ_LOCK_ON]  = lock_o && !lock_prev_r;
    assign irq_set[dpsr_pkg::IRQ_LOCK_OFF] = !lock_o && lock_prev_r;
    assign irq_set[dpsr_pkg::IRQ_OOR]      = secondary_ref_out_of_range_o
                                           && !oor_prev_r;
    assign irq_clr = (wr_en && (wb_adr_i == dpsr_pkg::REG_IRQ_STAT)
                     && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

    // Holdover one cycle ago, kept apart for the event edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_prev_r <= 1'b0;
        end else begin
            hold_prev_r <= holdover_o;
        end
    end

    // Sticky status, cleared by writing ones.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 4'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt from unmasked sticky bits.
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Control and mask writes, low byte lane only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= dpsr_pkg::CTRL_RESET;
            irq_mask_r <= dpsr_pkg::IRQ_MASK_RST;
        end else if (wr_en && wb_sel_i[0]) begin
            if (wb_adr_i == dpsr_pkg::REG_CTRL) begin
                ctrl_r <= wb_dat_i[5:0];
            end
            if (wb_adr_i == dpsr_pkg::REG_IRQ_MASK) begin
                irq_mask_r <= wb_dat_i[3:0];
            end
        end
    end

    // Acknowledge one cycle after the request; without a cycle the slave
    // stays idle and drives zero data.
    always_ff @(posedge clk_i) begin
        if (rst_i || !wb_cyc_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= bus_req;
            rdata_r <= 32'h0;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    dpsr_pkg::REG_CTRL:     rdata_r <= {26'h0, ctrl_r};
                    dpsr_pkg::REG_STATUS:   rdata_r <= {25'h0, mode_r, 1'b0,
                        secondary_ref_out_of_range_o, lock_o, holdover_o};
                    dpsr_pkg::REG_IRQ_STAT: rdata_r <= {28'h0, irq_stat_r};
                    dpsr_pkg::REG_IRQ_MASK: rdata_r <= {28'h0, irq_mask_r};
                    default:                rdata_r <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_win_close;
        win_end ##1 (win_cnt_r == 32'h0);
    endsequence

    AST_HOLD_FOLLOWS_MODE: assert property (
        ##1 (holdover_o == ($past(mode_nxt) == dpsr_pkg::PRI_HOLD
                         || $past(mode_nxt) == dpsr_pkg::SEC_HOLD)))
        else $error("holdover output disagrees with mode");
    AST_LOCK_ONLY_NORMAL: assert property (
        lock_o |-> (mode_r == dpsr_pkg::PRI_NORMAL
                 || mode_r == dpsr_pkg::SEC_NORMAL))
        else $error("lock shown outside normal mode");
    AST_FAST_IGNORED: assert property (
        (!pin_control_select_i && !ctrl_r[dpsr_pkg::CTRL_FAST])
        |=> !fast_lock_o)
        else $error("fast pin acted in microport mode");
    AST_FAST_PIN: assert property (
        (pin_control_select_i && fast_acquire_req_i) |=> fast_lock_o)
        else $error("fast request not honoured");
    AST_PCC_SAMPLE: assert property (
        frame_rise |=> (pcc_r == $past(phase_continuity_ctrl_i)))
        else $error("continuity not sampled at frame rise");
    AST_PCC_HOLD: assert property (
        !frame_rise |=> $stable(pcc_r))
        else $error("continuity changed between frame pulses");
    AST_HOLD_EXIT_FRAME: assert property (
        (mode_r == dpsr_pkg::PRI_HOLD && !frame_rise)
        |=> mode_r == dpsr_pkg::PRI_HOLD)
        else $error("primary holdover left without frame pulse");
    AST_OOR_WINDOW: assert property (
        !win_end |=> $stable(secondary_ref_out_of_range_o))
        else $error("out of range flag moved inside a window");
    AST_WINDOW_WRAP: assert property (
        s_win_close |-> ##1 (win_cnt_r == 32'h1))
        else $error("window counter did not restart");
    AST_QUARTER: assert property (
        (!eff_full && !eff_ds3) |=> (e3_ds3_clock_word_o
            == dpsr_pkg::SYN_E3_WORD / dpsr_pkg::QUARTER_DIV))
        else $error("quarter rate word wrong");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held more than one cycle");
endmodule
`default_nettype wire

// File: hw/dpsr_pkg.sv
// Constants shared by the DPLL status and rate pin block.
// Assumes a single 20 MHz master clock drives all of the logic.
package dpsr_pkg;
    // Master clock rate and period.
    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    // Measurement window, as a time and as a count of master cycles.
    localparam int unsigned WINDOW_MS     = 1000;
    localparam int unsigned WINDOW_CYCLES = (CLK_HZ / 1000) * WINDOW_MS;
    // Out-of-range limit in parts per million.
    localparam int unsigned OOR_PPM       = 12;
    // Nominal high-rate clock frequencies in kHz.
    localparam int unsigned E3_KHZ        = 34368;
    localparam int unsigned DS3_KHZ       = 44736;
    // Quarter-rate option divides the nominal rate by this.
    localparam int unsigned QUARTER_DIV   = 4;
    // Synthesiser word scale: word = f_khz * 2^24 / clock in kHz.
    localparam int unsigned SYN_SHIFT     = 24;
    localparam logic [31:0] SYN_E3_WORD   = 32'((64'(E3_KHZ) << SYN_SHIFT)
                                                / (CLK_HZ / 1000));
    localparam logic [31:0] SYN_DS3_WORD  = 32'((64'(DS3_KHZ) << SYN_SHIFT)
                                                / (CLK_HZ / 1000));
    // Reference input frequencies in Hz, by frequency select code.
    localparam int unsigned REF_HZ_0      = 8000;
    localparam int unsigned REF_HZ_1      = 1544000;
    localparam int unsigned REF_HZ_2      = 2048000;
    localparam int unsigned REF_HZ_3      = 19440000;
    // Register byte offsets.
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT  = 4'h8;
    localparam logic [3:0]  REG_IRQ_MASK  = 4'hC;
    // Control register fields.
    localparam int unsigned CTRL_DS3      = 0;
    localparam int unsigned CTRL_FULL     = 1;
    localparam int unsigned CTRL_FAST     = 2;
    localparam int unsigned CTRL_SEC      = 3;
    localparam int unsigned CTRL_FREQ_LO  = 4;
    localparam logic [5:0]  CTRL_RESET    = 6'h02;
    // Status register fields.
    localparam int unsigned STAT_HOLD     = 0;
    localparam int unsigned STAT_LOCK     = 1;
    localparam int unsigned STAT_OOR      = 2;
    localparam int unsigned STAT_MODE_LO  = 4;
    // Interrupt event bits.
    localparam int unsigned IRQ_NUM       = 4;
    localparam int unsigned IRQ_HOLD      = 0;
    localparam int unsigned IRQ_LOCK_ON   = 1;
    localparam int unsigned IRQ_LOCK_OFF  = 2;
    localparam int unsigned IRQ_OOR       = 3;
    localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
    // Operating modes of the control state machine.
    typedef enum logic [2:0] {
        FREERUN,
        PRI_NORMAL,
        PRI_HOLD,
        SEC_NORMAL,
        SEC_HOLD
    } dpsr_mode_t;
endpackage

// File: sim/dpsr_board_model.sv
// Board timing model: 8 kHz frame pulse and secondary reference ticks.
// Assumes one master clock; outputs move just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module dpsr_board_model #(
    parameter int unsigned FRAME_DIV = 2500  // Master cycles per frame.
) (
    input  wire logic        clk_i,             // Master clock.
    input  wire logic        rst_i,             // Synchronous reset.
    input  wire logic [15:0] tick_div_i,        // Cycles per ref period.
    output logic             frame_pulse_8k_o,  // Frame pulse.
    output logic             sec_ref_tick_o     // Secondary ref pulse.
);
    logic [15:0] fcnt_r;  // Position within the frame.
    logic [15:0] tcnt_r;  // Position within the reference period.
    // Frame counter; the pulse is four cycles wide for a clean rise.
    always_ff @(posedge clk_i) begin
        if (rst_i || fcnt_r >= 16'(FRAME_DIV - 1)) begin
            fcnt_r <= 16'h0000;
        end else begin
            fcnt_r <= fcnt_r + 16'h0001;
        end
    end
    // Reference counter; a shorter period restarts it at once.
    always_ff @(posedge clk_i) begin
        if (rst_i || tcnt_r >= tick_div_i - 16'h0001) begin
            tcnt_r <= 16'h0000;
        end else begin
            tcnt_r <= tcnt_r + 16'h0001;
        end
    end
    assign frame_pulse_8k_o = (fcnt_r < 16'h0004);
    assign sec_ref_tick_o = (tcnt_r == 16'h0000) && !rst_i;
endmodule
`default_nettype wire

// File: sim/dpsr_top_tb.sv
// Self-checking bench for the DPLL status and rate pin block.
// Assumes the board model supplies frame pulses and reference ticks.
`timescale 1ns/10ps
`default_nettype none
module dpsr_top_tb;
    localparam int unsigned WIN = 10000;  // Short window keeps runs brief.
    logic        clk_i = 1'b0;            // Master clock.
    logic        rst_i = 1'b1;            // Held for eight cycles.
    logic        pcs = 1'b0, ds3 = 1'b0, full = 1'b1, fst = 1'b0;
    logic        fail = 1'b0, lkd = 1'b0, pcc = 1'b0, req = 1'b0;
    logic        we = 1'b0, seen = 1'b0;  // Seen: a realign pulse came.
    logic        clr = 1'b0, sec = 1'b0;  // Clear seen; secondary select.
    logic [3:0]  adr = 4'h0;              // Bus address.
    logic [31:0] dat = 32'h00000000;      // Bus write data.
    logic [15:0] div = 16'h09C4;          // Cycles per secondary tick.
    logic [31:0] rdat, word;
    logic        ack, hold, lock, oor, fast, realign, irq, fp, tick;
    int          bad_count = 0, num_checks = 0, cyc_n = 0, n;
    dpsr_board_model u_dpsr_board_model (.clk_i(clk_i), .rst_i(rst_i),
        .tick_div_i(div), .frame_pulse_8k_o(fp), .sec_ref_tick_o(tick));
    dpsr_top #(.WINDOW_CYCLES(WIN)) u_dpsr_top (.clk_i(clk_i), .rst_i(rst_i),
        .pin_control_select_i(pcs), .ds3_select_pin_i(ds3),
        .high_rate_output_select_i(full), .fast_acquire_req_i(fst),
        .ref_select_sec_pin_i(sec), .ref_freq_select_pin_i(2'h0),
        .phase_continuity_ctrl_i(pcc), .frame_pulse_8k_i(fp),
        .ref_fail_i(fail), .loop_freq_locked_i(lkd), .sec_ref_tick_i(tick),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .holdover_o(hold), .lock_o(lock),
        .secondary_ref_out_of_range_o(oor), .fast_lock_o(fast),
        .phase_realign_o(realign), .e3_ds3_clock_word_o(word), .irq_o(irq));
    always #25 clk_i = ~clk_i;  // 50 ns period.
    // Cycle ceiling cuts a hang short; also latches realign pulses.
    always @(posedge clk_i) begin
        cyc_n++;
        if (clr) begin
            seen <= 1'b0;
        end else if (realign === 1'b1) begin
            seen <= 1'b1;
        end
        if (cyc_n == 80000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // One classic cycle; held until ack, then one idle cycle.
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, q);
        chk(q, e);
    endtask
    // Holdover exit with continuity level p; the exit waits for a frame in primary holdover only.
    task automatic exit_hold(input logic p);
        pcc <= p;
        fail <= 1'b1;
        for (n = 0; n < 4000 && fp !== 1'b1; n++) @(posedge clk_i);
        wait_n(8);
        clr <= 1'b1;
        fail <= 1'b0;
        wait_n(1);
        clr <= 1'b0;
        wait_n(999);
        chk({31'h0, hold}, 32'h1);
        for (n = 0; n < 4000 && hold !== 1'b0; n++) @(posedge clk_i);
        wait_n(2);
        chk({30'h0, seen, lock}, {30'h0, ~p, 1'b1});
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_n(2);
        rd(dpsr_pkg::REG_CTRL, 32'h00000002);
        rd(dpsr_pkg::REG_IRQ_MASK, 32'h0);
        rd(4'h2, 32'h0);
        chk(rdat, 32'h0);
        fst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(dpsr_pkg::REG_CTRL, 32'(i));
            wait_n(3);
            chk(word, (i[0] ? dpsr_pkg::SYN_DS3_WORD : dpsr_pkg::SYN_E3_WORD)
                >> (i[1] ? 0 : 2));
            chk({31'h0, fast}, 32'h0);
        end
        pcs <= 1'b1;
        ds3 <= 1'b1;
        full <= 1'b0;
        wait_n(3);
        chk(word, dpsr_pkg::SYN_DS3_WORD >> 2);
        chk({31'h0, fast}, 32'h1);
        fst <= 1'b0;
        lkd <= 1'b1;
        for (n = 0; n < 4000 && lock !== 1'b1; n++) @(posedge clk_i);
        chk({30'h0, fast, lock}, 32'h1);
        wr(dpsr_pkg::REG_IRQ_MASK, 32'h1);
        wr(dpsr_pkg::REG_IRQ_STAT, 32'hF);
        chk({31'h0, irq}, 32'h0);
        fail <= 1'b1;
        wait_n(3);
        chk({30'h0, lock, hold}, 32'h1);
        rd(dpsr_pkg::REG_STATUS, 32'h21);
        chk({31'h0, irq}, 32'h1);
        wr(dpsr_pkg::REG_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(dpsr_pkg::REG_IRQ_MASK, 32'h1);
        wr(dpsr_pkg::REG_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(dpsr_pkg::REG_IRQ_STAT, 32'h4);
        exit_hold(1'b0);
        sec <= 1'b1;
        exit_hold(1'b1);
        rd(dpsr_pkg::REG_STATUS, 32'h32);
        chk({31'h0, oor}, 32'h0);
        wr(dpsr_pkg::REG_IRQ_MASK, 32'h8);
        div <= 16'h07D0;
        wait_n(2 * WIN + 10);
        chk({30'h0, irq, oor}, 32'h3);
        div <= 16'h09C4;
        wait_n(2 * WIN + 10);
        chk({31'h0, oor}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
